// file: verilog/clamp_agc_control_regs.v
// register bank, sync detect, clamp sequencing and gain datapath for the
// video front end
// assumes: host bus decoded to a byte-wide write/read port, one clock
`timescale 1ns/1ps
`default_nettype none
`include "clamp_agc_defs.vh"
// Contract
// - halving bit halves all clamp currents
// - differential bit selects differential inputs
// - gain select picks one or two
// - voltage clamp enable activates voltage clamps
// - tristate bit floats digital outputs
// - polarity bit sets active sync level
// - gain word twelve bits, split low/high
// - gain waits for sync when asked
// - subtract black, multiply, add black back
// - black level field times sixteen
// - fine on-time code gives 2 to 256
// - coarse on-time uses same encoding
// - wait bit delays clamps until sync
// - direction acts only while clamp on
// - fine on bit triggers exact on-time
// - on-time counted after sync when enabled
// - on bits edge detected, clear first
// - coarse clamps have direction and on bits
// - sync input edge detected with polarity
module clamp_agc_control_regs #(
	parameter SAMPLE_W = 10,
	parameter GAIN_W   = 12
) (
	input  wire                I_CLK,
	input  wire                I_RESET,
	input  wire [4:0]          I_ADDR,
	input  wire [7:0]          I_WDATA,
	input  wire                I_WRITE,
	input  wire                I_READ,
	input  wire                I_SYNC_IN,
	input  wire [SAMPLE_W-1:0] I_SAMPLE,
	input  wire                I_SAMPLE_VALID,
	output reg  [7:0]          O_RDATA,
	output reg                 O_RVALID,
	output reg                 O_CLAMP_CURRENT_HALF,
	output reg                 O_DIFFERENTIAL_INPUT_SEL,
	output reg                 O_SAMPLE_HOLD_GAIN_SEL,
	output reg                 O_VOLTAGE_CLAMP_EN,
	output reg                 O_OUTPUT_TRISTATE_N,
	output reg                 O_GAIN_ACTIVE,
	output reg  [SAMPLE_W-1:0] O_SAMPLE,
	output reg                 O_SAMPLE_VALID,
	output reg  [2:0]          O_FINE_DRIVE,
	output reg  [2:0]          O_FINE_DIR,
	output reg  [2:0]          O_COARSE_DRIVE,
	output reg  [2:0]          O_COARSE_DIR
);
	reg  [7:0] input_sync_config;
	reg  [7:0] gain_word_low_reg;
	reg  [7:0] gain_word_high_ctrl;
	reg  [7:0] black_level_reg;
	reg  [7:0] clamp_timing_reg;
	reg  [7:0] fine_clamp_ctrl;
	reg  [7:0] coarse_clamp_ctrl;
	reg        sync_last;
	reg        gain_armed;
	reg  [7:0] next_rdata;
	wire       sync_level;
	wire       sync_pulse;
	wire [GAIN_W-1:0] gain_word;
	// seven-bit field times sixteen needs one bit more than a sample
	wire [6+`BLACK_LEVEL_SHIFT:0] black;
	wire [2:0] fine_drive;
	wire [2:0] fine_dir;
	wire [2:0] coarse_drive;
	wire [2:0] coarse_dir;

	// clip to the sample range
	function [SAMPLE_W-1:0] sat;
		input signed [SAMPLE_W+GAIN_W+1:0] v;
		begin
			if (v < 0)
				sat = {SAMPLE_W{1'b0}};
			else if (v > $signed({1'b0, {SAMPLE_W{1'b1}}}))
				sat = {SAMPLE_W{1'b1}};
			else
				sat = v[SAMPLE_W-1:0];
		end
	endfunction

	// reserved bits are masked off; the host is expected to write zero
	always @(posedge I_CLK) begin
		if (I_RESET) begin
			input_sync_config   <= `RESET_REG;
			gain_word_low_reg   <= `RESET_REG;
			gain_word_high_ctrl <= `RESET_REG;
			black_level_reg     <= `RESET_REG;
			clamp_timing_reg    <= `RESET_REG;
			fine_clamp_ctrl     <= `RESET_REG;
			coarse_clamp_ctrl   <= `RESET_REG;
		end else if (I_WRITE) begin
			case (I_ADDR)
			`ADDR_INPUT_SYNC_CONFIG: input_sync_config <= I_WDATA & `MASK_INPUT_SYNC_CONFIG;
			`ADDR_GAIN_WORD_LOW_REG: gain_word_low_reg <= I_WDATA;
			`ADDR_GAIN_WORD_HIGH_CTRL: gain_word_high_ctrl <= I_WDATA & `MASK_GAIN_WORD_HIGH;
			`ADDR_BLACK_LEVEL_REG: black_level_reg <= I_WDATA & `MASK_BLACK_LEVEL;
			`ADDR_CLAMP_TIMING_REG: clamp_timing_reg <= I_WDATA & `MASK_CLAMP_TIMING;
			`ADDR_FINE_CLAMP_CTRL: fine_clamp_ctrl <= I_WDATA & `MASK_CLAMP_CTRL;
			`ADDR_COARSE_CLAMP_CTRL: coarse_clamp_ctrl <= I_WDATA & `MASK_CLAMP_CTRL;
			default: ;
			endcase
		end
	end

	// read mux; unmapped offsets read as zero
	always @* begin
		next_rdata = 8'h00;
		case (I_ADDR)
		`ADDR_INPUT_SYNC_CONFIG:   next_rdata = input_sync_config;
		`ADDR_GAIN_WORD_LOW_REG:   next_rdata = gain_word_low_reg;
		`ADDR_GAIN_WORD_HIGH_CTRL: next_rdata = gain_word_high_ctrl;
		`ADDR_BLACK_LEVEL_REG:     next_rdata = black_level_reg;
		`ADDR_CLAMP_TIMING_REG:    next_rdata = clamp_timing_reg;
		`ADDR_FINE_CLAMP_CTRL:     next_rdata = fine_clamp_ctrl;
		`ADDR_COARSE_CLAMP_CTRL:   next_rdata = coarse_clamp_ctrl;
		default:                   next_rdata = 8'h00;
		endcase
	end

	always @(posedge I_CLK) begin
		if (I_RESET) begin
			O_RDATA  <= 8'h00;
			O_RVALID <= 1'b0;
		end else begin
			O_RVALID <= I_READ;
			if (I_READ)
				O_RDATA <= next_rdata;
		end
	end

	// sync normalised to active high, then leading edge detected
	assign sync_level = I_SYNC_IN ~^ input_sync_config[`BIT_SYNC_POLARITY_SEL];
	assign sync_pulse = sync_level & ~sync_last;

	always @(posedge I_CLK) begin
		if (I_RESET)
			sync_last <= 1'b0;
		else
			sync_last <= sync_level;
	end

	// static mode controls go straight out of flip-flops
	always @(posedge I_CLK) begin
		if (I_RESET) begin
			O_CLAMP_CURRENT_HALF     <= 1'b0;
			O_DIFFERENTIAL_INPUT_SEL <= 1'b0;
			O_SAMPLE_HOLD_GAIN_SEL   <= 1'b0;
			O_VOLTAGE_CLAMP_EN       <= 1'b0;
			O_OUTPUT_TRISTATE_N      <= 1'b1;
		end else begin
			O_CLAMP_CURRENT_HALF     <= input_sync_config[`BIT_CLAMP_CURRENT_HALF];
			O_DIFFERENTIAL_INPUT_SEL <= input_sync_config[`BIT_DIFFERENTIAL_IN_SEL];
			O_SAMPLE_HOLD_GAIN_SEL   <= input_sync_config[`BIT_SAMPLE_HOLD_GAIN_SEL];
			O_VOLTAGE_CLAMP_EN       <= input_sync_config[`BIT_VOLTAGE_CLAMP_EN];
			// low means the pins float
			O_OUTPUT_TRISTATE_N      <= ~input_sync_config[`BIT_OUTPUT_TRISTATE];
		end
	end

	assign gain_word = {gain_word_high_ctrl[3:0], gain_word_low_reg};
	assign black = {black_level_reg[6:0], {`BLACK_LEVEL_SHIFT{1'b0}}};

	// gain turns on at once, or at next sync when waiting is asked for;
	// clearing the wait bit while armed switches gain on right away
	always @(posedge I_CLK) begin
		if (I_RESET) begin
			O_GAIN_ACTIVE <= 1'b0;
			gain_armed    <= 1'b0;
		end else begin
			if (I_WRITE && I_ADDR == `ADDR_GAIN_WORD_HIGH_CTRL &&
			    I_WDATA[`BIT_GAIN_WAIT_FOR_SYNC]) begin
				O_GAIN_ACTIVE <= 1'b0;
				gain_armed    <= 1'b1;
			end else if (!gain_word_high_ctrl[`BIT_GAIN_WAIT_FOR_SYNC]) begin
				O_GAIN_ACTIVE <= 1'b1;
				gain_armed    <= 1'b0;
			end else if (gain_armed && sync_pulse) begin
				O_GAIN_ACTIVE <= 1'b1;
				gain_armed    <= 1'b0;
			end
		end
	end

	// gain is 4.8 fixed point; bypassed while gain is inactive
	always @(posedge I_CLK) begin
		if (I_RESET) begin
			O_SAMPLE       <= {SAMPLE_W{1'b0}};
			O_SAMPLE_VALID <= 1'b0;
		end else begin
			O_SAMPLE_VALID <= I_SAMPLE_VALID;
			if (I_SAMPLE_VALID) begin
				if (O_GAIN_ACTIVE)
					O_SAMPLE <= sat(((($signed({2'b00, I_SAMPLE}) -
						$signed({1'b0, black})) * $signed({1'b0, gain_word}))
						>>> `GAIN_FRAC_BITS) + $signed({1'b0, black}));
				else
					O_SAMPLE <= I_SAMPLE;
			end
		end
	end

	// one timer per clamp; fine share one code, coarse another
	genvar k;
	generate
		for (k = 0; k < 3; k = k + 1) begin : g_clamp
			clamp_timer #(.CW(9)) u_fine (
				.i_clk        (I_CLK),
				.i_reset      (I_RESET),
				.i_on_bit     (fine_clamp_ctrl[2*k+1]),
				.i_dir_bit    (fine_clamp_ctrl[2*k]),
				.i_wait_sync  (clamp_timing_reg[`BIT_CLAMP_WAIT_FOR_SYNC]),
				.i_sync_pulse (sync_pulse),
				.i_on_code    (clamp_timing_reg[2:0]),
				.o_drive      (fine_drive[k]),
				.o_dir        (fine_dir[k])
			);
			clamp_timer #(.CW(9)) u_coarse (
				.i_clk        (I_CLK),
				.i_reset      (I_RESET),
				.i_on_bit     (coarse_clamp_ctrl[2*k+1]),
				.i_dir_bit    (coarse_clamp_ctrl[2*k]),
				.i_wait_sync  (clamp_timing_reg[`BIT_CLAMP_WAIT_FOR_SYNC]),
				.i_sync_pulse (sync_pulse),
				.i_on_code    (clamp_timing_reg[5:3]),
				.o_drive      (coarse_drive[k]),
				.o_dir        (coarse_dir[k])
			);
		end
	endgenerate

	// retimed so every top output leaves a flip-flop of this module;
	// costs one cycle of latency on the clamp pins
	always @(posedge I_CLK) begin
		if (I_RESET) begin
			O_FINE_DRIVE   <= 3'h0;
			O_FINE_DIR     <= 3'h0;
			O_COARSE_DRIVE <= 3'h0;
			O_COARSE_DIR   <= 3'h0;
		end else begin
			O_FINE_DRIVE   <= fine_drive;
			O_FINE_DIR     <= fine_dir;
			O_COARSE_DRIVE <= coarse_drive;
			O_COARSE_DIR   <= coarse_dir;
		end
	end
endmodule // clamp_agc_control_regs
`default_nettype wire

// file: verilog/clamp_agc_defs.vh
// register offsets, field positions and reset values for the clamp and
// gain control registers
// assumes: included by bare name from files under verilog/
`ifndef CLAMP_AGC_DEFS_VH
`define CLAMP_AGC_DEFS_VH
`define ADDR_INPUT_SYNC_CONFIG   5'h03
`define ADDR_GAIN_WORD_LOW_REG   5'h04
`define ADDR_GAIN_WORD_HIGH_CTRL 5'h05
`define ADDR_BLACK_LEVEL_REG     5'h06
`define ADDR_CLAMP_TIMING_REG    5'h07
`define ADDR_FINE_CLAMP_CTRL     5'h08
`define ADDR_COARSE_CLAMP_CTRL   5'h09
`define BIT_CLAMP_CURRENT_HALF   0
`define BIT_DIFFERENTIAL_IN_SEL  1
`define BIT_SAMPLE_HOLD_GAIN_SEL 2
`define BIT_VOLTAGE_CLAMP_EN     3
`define BIT_OUTPUT_TRISTATE      4
`define BIT_SYNC_POLARITY_SEL    5
`define BIT_GAIN_WAIT_FOR_SYNC   4
`define BIT_CLAMP_WAIT_FOR_SYNC  6
`define MASK_INPUT_SYNC_CONFIG   8'h3F
`define MASK_GAIN_WORD_HIGH      8'h1F
`define MASK_BLACK_LEVEL         8'h7F
`define MASK_CLAMP_TIMING        8'h7F
`define MASK_CLAMP_CTRL          8'h3F
`define RESET_REG                8'h00
`define BLACK_LEVEL_SHIFT        4
`define GAIN_FRAC_BITS           8
`endif

// file: verilog/clamp_timer.v
// one clamp on-time counter with rising-edge trigger on its on bit
// assumes: on bit and sync pulse are synchronous to the sample clock
`timescale 1ns/1ps
`default_nettype none
module clamp_timer #(
	parameter CW = 9
) (
	input  wire          i_clk,
	input  wire          i_reset,
	input  wire          i_on_bit,
	input  wire          i_dir_bit,
	input  wire          i_wait_sync,
	input  wire          i_sync_pulse,
	input  wire [2:0]    i_on_code,
	output reg           o_drive,
	output reg           o_dir
);
	reg          on_last;
	reg          armed;
	reg [CW-1:0] count;
	wire         rise;
	wire         start;

	// cycles for a code: 2 shifted left by the code, 2 to 256
	function [CW-1:0] on_cycles;
		input [2:0] code;
		begin
			on_cycles = {{(CW-2){1'b0}}, 2'b10} << code;
		end
	endfunction

	assign rise  = i_on_bit & ~on_last;
	// armed trigger waits for sync only while waiting is asked for
	assign start = (armed | rise) & (~i_wait_sync | i_sync_pulse);

	// counter drops the drive exactly after the programmed count
	always @(posedge i_clk) begin
		if (i_reset) begin
			on_last <= 1'b0;
			armed   <= 1'b0;
			count   <= {CW{1'b0}};
			o_drive <= 1'b0;
			o_dir   <= 1'b0;
		end else begin
			on_last <= i_on_bit;
			if (start) begin
				armed   <= 1'b0;
				count   <= on_cycles(i_on_code) - {{(CW-1){1'b0}}, 1'b1};
				o_drive <= 1'b1;
			end else begin
				if (rise)
					armed <= 1'b1;
				if (count != {CW{1'b0}})
					count <= count - {{(CW-1){1'b0}}, 1'b1};
				else
					o_drive <= 1'b0;
			end
			// direction only acts while the clamp is on
			o_dir <= (start | (o_drive & count != {CW{1'b0}})) & i_dir_bit;
		end
	end
endmodule // clamp_timer
`default_nettype wire

// file: dv/clamp_agc_props.sv
// checker for the clamp and gain register bank
// assumes: sees only top ports, writes at least two cycles apart
`timescale 1ns/1ps
`default_nettype none
module clamp_agc_props (
	input wire logic       I_CLK,
	input wire logic       I_RESET,
	input wire logic [4:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic       I_WRITE,
	input wire logic       I_READ,
	input wire logic [7:0] O_RDATA,
	input wire logic       O_RVALID,
	input wire logic       O_CLAMP_CURRENT_HALF,
	input wire logic       O_OUTPUT_TRISTATE_N,
	input wire logic [2:0] O_FINE_DRIVE,
	input wire logic [2:0] O_FINE_DIR,
	input wire logic [2:0] O_COARSE_DRIVE,
	input wire logic [2:0] O_COARSE_DIR
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RESET);
	logic [2:0] fcode;
	logic       fon0;
	logic       cwait;
	logic [9:0] cnt;
	// shadow of timing fields; a retrigger mid-interval is not modelled
	always_ff @(posedge I_CLK) begin
		cnt <= O_FINE_DRIVE[0] ? cnt + 10'h001 : 10'h000;
		if (I_RESET) begin
			fcode <= 3'h0;
			cwait <= 1'b0;
			fon0 <= 1'b0;
		end else if (I_WRITE && I_ADDR == 5'h07) begin
			fcode <= I_WDATA[2:0];
			cwait <= I_WDATA[6];
		end else if (I_WRITE && I_ADDR == 5'h08) begin
			fon0 <= I_WDATA[1];
		end
	end
	a_read_answer: assert property (I_READ |=> O_RVALID)
		else $error("read strobe got no answer");
	a_black_width: assert property (I_READ && I_ADDR == 5'h06 |=> !O_RDATA[7])
		else $error("black level wider than seven bits");
	a_halving_bit: assert property (I_WRITE && I_ADDR == 5'h03 |=>
		##2 O_CLAMP_CURRENT_HALF == $past(I_WDATA[0], 3))
		else $error("halving output does not follow write");
	a_tristate_bit: assert property (I_WRITE && I_ADDR == 5'h03 |=>
		##2 O_OUTPUT_TRISTATE_N != $past(I_WDATA[4], 3))
		else $error("tristate output does not follow write");
	a_fine_dir: assert property ((O_FINE_DIR & ~O_FINE_DRIVE) == 3'h0)
		else $error("fine direction shown while clamp off");
	a_coarse_dir: assert property ((O_COARSE_DIR & ~O_COARSE_DRIVE) == 3'h0)
		else $error("coarse direction shown while clamp off");
	a_fine_length: assert property ($fell(O_FINE_DRIVE[0]) |-> cnt == (10'h002 << fcode))
		else $error("fine clamp on-time wrong");
	a_fine_start: assert property (I_WRITE && I_ADDR == 5'h08 && I_WDATA[1]
		&& !fon0 && !cwait |-> ##[2:4] O_FINE_DRIVE[0])
		else $error("fine clamp did not start");
endmodule // clamp_agc_props
bind clamp_agc_control_regs clamp_agc_props i_props (.I_CLK(I_CLK),
	.I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WRITE(I_WRITE),
	.I_READ(I_READ), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
	.O_CLAMP_CURRENT_HALF(O_CLAMP_CURRENT_HALF),
	.O_OUTPUT_TRISTATE_N(O_OUTPUT_TRISTATE_N), .O_FINE_DRIVE(O_FINE_DRIVE),
	.O_FINE_DIR(O_FINE_DIR), .O_COARSE_DRIVE(O_COARSE_DRIVE),
	.O_COARSE_DIR(O_COARSE_DIR));
`default_nettype wire

// file: dv/host_model.sv
// host controller model: byte writes and reads on the register port
// assumes: one-cycle strobes, read data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic       i_clk,
	output logic [4:0]      o_addr,
	output logic [7:0]      o_wdata,
	output logic            o_write,
	output logic            o_read,
	input  wire logic [7:0] i_rdata
);
	// idle bus shows the inverse of the last value, never a stale copy
	initial begin
		o_addr = 5'h1F;
		o_wdata = 8'hFF;
		o_write = 1'b0;
		o_read = 1'b0;
	end
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_write <= 1'b1;
		@(posedge i_clk);
		o_write <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] q);
		@(posedge i_clk);
		o_addr <= a;
		o_read <= 1'b1;
		@(posedge i_clk);
		o_read <= 1'b0;
		o_addr <= ~a;
		@(posedge i_clk);
		q = i_rdata;
	endtask
endmodule // host_model
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the clamp and gain register bank
// assumes: host model drives the register port, bench drives sync, samples
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clk, rst, sync, svalid, write, read, rvalid, ovalid;
	logic       half, diff, shg, vce, tri_n, gact;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, q, d;
	logic [9:0] sin, sout;
	logic [2:0] fdrv, fdir, cdrv, cdir;
	int         fail_count, num_checks, n, g, b, s;
	clamp_agc_control_regs i_dut (.I_CLK(clk), .I_RESET(rst), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WRITE(write), .I_READ(read), .I_SYNC_IN(sync),
		.I_SAMPLE(sin), .I_SAMPLE_VALID(svalid), .O_RDATA(rdata),
		.O_RVALID(rvalid), .O_CLAMP_CURRENT_HALF(half),
		.O_DIFFERENTIAL_INPUT_SEL(diff), .O_SAMPLE_HOLD_GAIN_SEL(shg),
		.O_VOLTAGE_CLAMP_EN(vce), .O_OUTPUT_TRISTATE_N(tri_n),
		.O_GAIN_ACTIVE(gact), .O_SAMPLE(sout), .O_SAMPLE_VALID(ovalid),
		.O_FINE_DRIVE(fdrv), .O_FINE_DIR(fdir), .O_COARSE_DRIVE(cdrv),
		.O_COARSE_DIR(cdir));
	host_model i_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata),
		.o_write(write), .o_read(read), .i_rdata(rdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			fail_count++;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic [7:0] mask(input logic [4:0] a);
		mask = a == 5'h04 ? 8'hFF : a == 5'h05 ? 8'h1F : a == 5'h06 ? 8'h7F
			: a == 5'h03 ? 8'h3F : 8'h00;
	endfunction
	// saturating black-level-relative gain, four integer and eight fraction bits
	function automatic logic [9:0] gained(input int s, input int b, input int g);
		int p;
		p = (((s - b * 16) * g) >>> 8) + b * 16;
		gained = p < 0 ? 10'h000 : p > 1023 ? 10'h3FF : p[9:0];
	endfunction
	function automatic logic drv(input logic [4:0] a, input int k);
		drv = a == 5'h08 ? fdrv[k] : cdrv[k];
	endfunction
	// trigger one clamp, optionally through a sync pulse, and time its drive
	task automatic pulse(input logic [4:0] a, input int k, input int c, input int w);
		i_host.wr(a, 8'h00);
		i_host.wr(a, 8'h03 << (2 * k));
		if (w) begin
			repeat (10) @(posedge clk);
			chk({fdrv, cdrv, gact}, 0);
			sync <= ~sync;
			@(posedge clk);
			sync <= ~sync;
		end
		for (n = 0; n < 20 && !drv(a, k); n++) @(posedge clk);
		for (n = 0; n < 300 && drv(a, k); n++) begin
			chk((a == 5'h08 ? fdir : cdir) >> k & 3'h1, 1);
			@(posedge clk);
		end
		chk(n, 2 << c);
		if (w) chk(gact, 1);
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#(40 * 40000);
		fail_count++;
		stop_test;
	end
	initial begin
		fail_count = 0;
		num_checks = 0;
		{rst, sync, svalid, sin} = {3'b110, 10'h000};
		void'($urandom(32'hD735896F));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(tri_n, 1);
		for (int i = 0; i < 12; i++) begin
			i_host.rd(5'(i), q);
			chk(q, 0);
		end
		// random writes with reserved bits clear must read back unchanged
		repeat (16) begin
			// the host keeps reserved bits at zero
			addr_pick: begin
				n = 3 + $urandom % 5;
				if (n == 7) n = 12;
				d = 8'($urandom) & mask(5'(n));
			end
			i_host.wr(5'(n), d);
			i_host.rd(5'(n), q);
			chk(q, d & mask(5'(n)));
			if (n == 3) chk({tri_n, vce, shg, diff, half}, {~d[4], d[3:0]});
		end
		for (int c = 0; c < 8; c++) begin
			i_host.wr(5'h07, {2'b00, 3'(7 - c), 3'(c)});
			pulse(5'h08, c % 3, c, 0);
			pulse(5'h09, c % 3, 7 - c, 0);
		end
		// armed clamp and gain stage wait for a sync of either polarity
		for (int p = 0; p < 2; p++) begin
			sync <= ~p[0];
			i_host.wr(5'h03, {2'b00, p[0], 5'h00});
			i_host.wr(5'h05, 8'h11);
			i_host.wr(5'h07, 8'h41);
			pulse(5'h08, p, 1, 1);
		end
		// black level removed around the gain multiply, unity gain first
		for (int i = 0; i < 24; i++) begin
			g = i == 0 ? 256 : $urandom % 4096;
			b = $urandom % 128;
			s = i == 1 ? 1023 : $urandom % 1024;
			i_host.wr(5'h04, 8'(g));
			// pass two parks the gain stage on a wait for sync that pass three clears
			i_host.wr(5'h05, 8'(g >> 8) | (i == 2 ? 8'h10 : 8'h00));
			i_host.wr(5'h06, 8'(b));
			sin <= 10'(s);
			svalid <= 1'b1;
			@(posedge clk);
			svalid <= 1'b0;
			@(posedge clk);
			chk(sout, i == 2 ? 10'(s) : gained(s, b, g));
			chk(ovalid, 1);
		end
		stop_test;
	end
endmodule // tb
`default_nettype wire
